/* core/target_decode_pkg.sv */
// Shared constants and types for the PCI target image decode stage
package target_decode_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IMAGE0_CONTROL  = 8'h00;
  localparam logic [7:0] IDX_IMAGE1_CONTROL  = 8'h01;
  localparam logic [7:0] IDX_IMAGE0_BASE     = 8'h02;
  localparam logic [7:0] IDX_IMAGE1_BASE     = 8'h03;
  localparam logic [7:0] IDX_IMAGE0_XLATE    = 8'h04;
  localparam logic [7:0] IDX_IMAGE1_XLATE    = 8'h05;
  localparam logic [7:0] IDX_MISC_PRIMARY    = 8'h06;
  localparam logic [7:0] IDX_MISC_SECONDARY  = 8'h07;
  localparam logic [7:0] IDX_STATUS          = 8'h08;

  // Image control field positions
  localparam int CTL_ENABLE       = 31;
  localparam int CTL_SPACE        = 30;
  localparam int CTL_POSTED       = 29;
  localparam int CTL_PREFETCH     = 28;
  localparam int CTL_BURST_WRITE  = 27;
  localparam int CTL_ENDIAN_INV   = 26;
  localparam int CTL_WIDTH_LSB    = 24;
  localparam int CTL_CODE_LSB     = 20;
  localparam int CTL_BSIZE_LSB    = 16;

  // Miscellaneous control field positions
  localparam int MISC_COUNT_LSB   = 0;
  localparam int MISC_BYTE_ORDER  = 8;
  localparam int MISC_PER_IMAGE   = 8;
  localparam int MISC_BURST4      = 9;
  localparam int MISC_SINGLE_PF   = 10;
  localparam int MISC_HOLD_BUSY   = 11;

  // Status field positions
  localparam int STAT_SPEED_LSB   = 0;
  localparam int STAT_HIT0        = 2;
  localparam int STAT_HIT1        = 3;
  localparam int STAT_BUSY        = 4;
  localparam int STAT_CS_CONFLICT = 5;

  // Reset values
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [15:0] ADDR16_RESET  = 16'h0000;
  localparam logic [11:0] MISC_RESET    = 12'h000;

  // Decode speed code reported in status: medium
  localparam logic [1:0] DEVSEL_MEDIUM  = 2'h1;

  // PCI command codes
  localparam logic [3:0] CMD_IO_READ    = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE   = 4'h3;
  localparam logic [3:0] CMD_MEM_READ   = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE  = 4'h7;
  localparam logic [3:0] CMD_CFG_READ   = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE  = 4'hB;
  localparam logic [3:0] CMD_MEM_RD_MUL = 4'hC;
  localparam logic [3:0] CMD_MEM_RD_LN  = 4'hE;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

  typedef struct packed {
    logic       enable;
    logic       space_select;
    logic       posted_write_enable;
    logic       prefetch_enable;
    logic       burst_write_enable;
    logic       endian_invert;
    logic [1:0] port_width;
    logic [3:0] transaction_code_field;
    logic [3:0] block_size;
  } image_ctrl_t;

  typedef struct packed {
    logic [31:0] address;
    logic [3:0]  transaction_code;
    logic        write;
    logic        io_space;
    logic        image;
    logic        posted;
    logic [1:0]  port_width;
    logic        prefetch;
    logic        burst_write;
    logic        little_endian;
    logic [5:0]  prefetch_count;
    logic        burst4;
    logic        single_beat_prefetch;
    logic        hold_bus_busy;
  } local_bus_req_t;

  typedef struct packed {
    logic       write;
    logic [5:0] dword;
    logic [3:0] byte_enable_n;
  } config_req_t;

endpackage

/* core/pci_target_image_decode.sv */
// Two-image PCI target decode, address translation and local-bus request
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pci_target_image_decode (
  // Clock and reset
  input  wire logic                             clock,
  input  wire logic                             srst,
  // Register port
  input  wire logic [7:0]                       reg_addr,
  input  wire logic [31:0]                      reg_wdata,
  input  wire logic                             reg_write,
  input  wire logic                             reg_read,
  output logic [31:0]                           reg_rdata,
  // PCI bus, sampled on this clock
  input  wire logic                             frame_n,
  input  wire logic                             irdy_n,
  input  wire logic                             idsel,
  input  wire logic [31:0]                      ad_in,
  input  wire logic [3:0]                       cbe_n,
  output logic                                  devsel_n_out,
  output logic                                  devsel_oe,
  // Local-bus master request
  output logic                                  lb_valid,
  input  wire logic                             lb_ready,
  output target_decode_pkg::local_bus_req_t     lb_req,
  output logic [3:0]                            transaction_code,
  input  wire logic                             lb_mastering,
  // Local chip selects
  input  wire logic                             register_chip_select_n,
  input  wire logic                             config_chip_select_n,
  // Configuration access toward config space
  output logic                                  cfg_valid,
  output target_decode_pkg::config_req_t        cfg_req
);
  import target_decode_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_DECODE = 4'b0010,
    ST_CLAIM  = 4'b0100,
    ST_SKIP   = 4'b1000
  } state_t;

  // Upper-bit mask kept by a block size code
  function automatic logic [15:0] size_mask(input logic [3:0] bsize);
    size_mask = 16'hFFFF << bsize;
  endfunction

  function automatic logic [7:0] reg_at(input logic [7:0] idx);
    reg_at = {idx[5:0], 2'b00};
  endfunction

  // Command folding: aliases map onto the basic memory commands
  function automatic logic [3:0] fold_cmd(input logic [3:0] cmd);
    unique case (cmd)
      CMD_MEM_RD_MUL, CMD_MEM_RD_LN: fold_cmd = CMD_MEM_READ;
      CMD_MEM_WR_INV:                fold_cmd = CMD_MEM_WRITE;
      default:                       fold_cmd = cmd;
    endcase
  endfunction

  // Local upper address: translation bits above the mask, PCI bits below
  function automatic logic [15:0] xlate(input logic [15:0] pci_hi,
                                        input logic [15:0] ta,
                                        input logic [3:0]  bsize);
    xlate = (ta & size_mask(bsize)) | (pci_hi & ~size_mask(bsize));
  endfunction

  function automatic image_ctrl_t to_ctrl(input logic [31:0] w);
    to_ctrl.enable                 = w[CTL_ENABLE];
    to_ctrl.space_select           = w[CTL_SPACE];
    to_ctrl.posted_write_enable    = w[CTL_POSTED];
    to_ctrl.prefetch_enable        = w[CTL_PREFETCH];
    to_ctrl.burst_write_enable     = w[CTL_BURST_WRITE];
    to_ctrl.endian_invert          = w[CTL_ENDIAN_INV];
    to_ctrl.port_width             = w[CTL_WIDTH_LSB +: 2];
    to_ctrl.transaction_code_field = w[CTL_CODE_LSB +: 4];
    to_ctrl.block_size             = w[CTL_BSIZE_LSB +: 4];
  endfunction

  // Registers
  logic [31:0]    ctl0_q, ctl1_q;
  logic [15:0]    base0_q, base1_q;
  logic [15:0]    ta0_q, ta1_q;
  logic [11:0]    misc1_q, misc2_q;
  logic           conflict_q;
  logic           hit0_q, hit1_q;
  logic [31:0]    rdata_q;

  // Bus tracking
  state_t         state_q, state_d;
  logic           frame_prev_q;
  logic [31:0]    ad_q;
  logic [3:0]     cmd_q;
  logic [3:0]     be_q;
  logic           idsel_q;
  logic           devsel_n_q;
  logic           devsel_oe_q;
  logic           lb_valid_q;
  local_bus_req_t lb_req_q;
  logic           cfg_valid_q;
  config_req_t    cfg_req_q;

  image_ctrl_t    img0, img1, sel;
  logic           start, frame_done;
  logic           is_mem, is_io, is_write, cfg_type0;
  logic           match0, match1, hit, any_enable;
  logic [15:0]    sel_ta;
  logic [15:0]    m0, m1;
  logic           sel_image;
  logic [3:0]     fcmd;

  assign img0 = to_ctrl(ctl0_q);
  assign img1 = to_ctrl(ctl1_q);
  assign m0   = size_mask(img0.block_size);
  assign m1   = size_mask(img1.block_size);

  // Address-phase start: FRAME newly asserted while the channel is free
  assign start      = (state_q == ST_IDLE) && !frame_n && frame_prev_q
                      && !lb_valid_q;
  assign frame_done = frame_n && irdy_n;

  // Command classes from the captured address phase
  assign fcmd      = fold_cmd(cmd_q);
  assign is_mem    = (fcmd == CMD_MEM_READ) || (fcmd == CMD_MEM_WRITE);
  assign is_io     = (fcmd == CMD_IO_READ) || (fcmd == CMD_IO_WRITE);
  assign is_write  = (fcmd == CMD_MEM_WRITE) || (fcmd == CMD_IO_WRITE);
  // Type 1 has AD[1:0]=01 and is never claimed
  assign cfg_type0 = ((cmd_q == CMD_CFG_READ) || (cmd_q == CMD_CFG_WRITE))
                     && idsel_q && (ad_q[1:0] == 2'b00);

  // Image match: enabled, space agrees, masked upper bits equal
  assign match0 = img0.enable
                  && (img0.space_select ? is_io : is_mem)
                  && ((ad_q[31:16] & m0) == (base0_q & m0));
  assign match1 = img1.enable
                  && (img1.space_select ? is_io : is_mem)
                  && ((ad_q[31:16] & m1) == (base1_q & m1));
  assign any_enable = img0.enable || img1.enable;
  // Image 0 wins if software breaks the no-overlap agreement
  assign hit       = any_enable && (match0 || match1);
  assign sel_image = !match0;
  assign sel       = sel_image ? img1 : img0;
  assign sel_ta    = sel_image ? ta1_q : ta0_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start) state_d = ST_DECODE;
      ST_DECODE: state_d = (hit || cfg_type0) ? ST_CLAIM : ST_SKIP;
      ST_CLAIM, ST_SKIP: if (frame_done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q      <= ST_IDLE;
      frame_prev_q <= 1'b1;
      ad_q         <= '0;
      cmd_q        <= '0;
      be_q         <= '0;
      idsel_q      <= 1'b0;
    end else begin
      state_q      <= state_d;
      frame_prev_q <= frame_n;
      if (start) begin
        ad_q    <= ad_in;
        cmd_q   <= cbe_n;
        idsel_q <= idsel;
      end
      if (state_q == ST_DECODE) begin
        be_q <= cbe_n;
      end
    end
  end

  // DEVSEL: low two edges after FRAME is sampled; driven high one more
  always_ff @(posedge clock) begin
    if (srst) begin
      devsel_n_q  <= 1'b1;
      devsel_oe_q <= 1'b0;
    end else begin
      devsel_n_q  <= !(state_d == ST_CLAIM);
      devsel_oe_q <= (state_d == ST_CLAIM) || !devsel_n_q;
    end
  end

  assign devsel_n_out = devsel_n_q;
  assign devsel_oe    = devsel_oe_q;

  // Local-bus request for memory and I/O hits only
  always_ff @(posedge clock) begin
    if (srst) begin
      lb_valid_q <= 1'b0;
      lb_req_q   <= '0;
    end else begin
      if (lb_valid_q && lb_ready) begin
        lb_valid_q <= 1'b0;
      end
      if (state_q == ST_DECODE && hit) begin
        lb_valid_q <= 1'b1;
        lb_req_q.address <= {xlate(ad_q[31:16], sel_ta, sel.block_size),
                             ad_q[15:0]};
        lb_req_q.transaction_code <= sel.transaction_code_field;
        lb_req_q.write       <= is_write;
        lb_req_q.io_space    <= is_io;
        lb_req_q.image       <= sel_image;
        lb_req_q.posted      <= is_write && sel.posted_write_enable;
        lb_req_q.port_width  <= sel.port_width;
        lb_req_q.prefetch    <= !is_write && sel.prefetch_enable;
        lb_req_q.burst_write <= is_write
                                && sel.burst_write_enable;
        lb_req_q.little_endian <= misc1_q[MISC_BYTE_ORDER]
                                  ^ sel.endian_invert;
        lb_req_q.prefetch_count <= (sel_image && misc2_q[MISC_PER_IMAGE])
                                   ? misc2_q[MISC_COUNT_LSB +: 6]
                                   : misc1_q[MISC_COUNT_LSB +: 6];
        lb_req_q.burst4 <= misc2_q[MISC_BURST4];
        lb_req_q.single_beat_prefetch <= misc2_q[MISC_SINGLE_PF];
        lb_req_q.hold_bus_busy <= misc2_q[MISC_HOLD_BUSY];
      end
    end
  end

  assign lb_valid         = lb_valid_q;
  assign lb_req           = lb_req_q;
  assign transaction_code = lb_req_q.transaction_code;

  // Configuration accesses stay inside the device
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_valid_q <= 1'b0;
      cfg_req_q   <= '0;
    end else begin
      cfg_valid_q <= (state_q == ST_DECODE) && !hit && cfg_type0;
      if (state_q == ST_DECODE) begin
        cfg_req_q.write         <= (cmd_q == CMD_CFG_WRITE);
        cfg_req_q.dword         <= ad_q[7:2];
        cfg_req_q.byte_enable_n <= cbe_n;
      end
    end
  end

  assign cfg_valid = cfg_valid_q;
  assign cfg_req   = cfg_req_q;

  // Register writes
  logic wr_ctl0, wr_ctl1, wr_base0, wr_base1, wr_ta0, wr_ta1;
  logic wr_misc1, wr_misc2, wr_stat, cs_clash;

  assign wr_ctl0  = reg_write && (reg_addr == reg_at(IDX_IMAGE0_CONTROL));
  assign wr_ctl1  = reg_write && (reg_addr == reg_at(IDX_IMAGE1_CONTROL));
  assign wr_base0 = reg_write && (reg_addr == reg_at(IDX_IMAGE0_BASE));
  assign wr_base1 = reg_write && (reg_addr == reg_at(IDX_IMAGE1_BASE));
  assign wr_ta0   = reg_write && (reg_addr == reg_at(IDX_IMAGE0_XLATE));
  assign wr_ta1   = reg_write && (reg_addr == reg_at(IDX_IMAGE1_XLATE));
  assign wr_misc1 = reg_write && (reg_addr == reg_at(IDX_MISC_PRIMARY));
  assign wr_misc2 = reg_write && (reg_addr == reg_at(IDX_MISC_SECONDARY));
  assign wr_stat  = reg_write && (reg_addr == reg_at(IDX_STATUS));
  // Chip selects must stay idle while we master the local bus
  assign cs_clash = lb_mastering
                    && !(register_chip_select_n
                         && config_chip_select_n);

  always_ff @(posedge clock) begin
    if (srst) begin
      ctl0_q     <= CONTROL_RESET;
      ctl1_q     <= CONTROL_RESET;
      base0_q    <= ADDR16_RESET;
      base1_q    <= ADDR16_RESET;
      ta0_q      <= ADDR16_RESET;
      ta1_q      <= ADDR16_RESET;
      misc1_q    <= MISC_RESET;
      misc2_q    <= MISC_RESET;
      conflict_q <= 1'b0;
      hit0_q     <= 1'b0;
      hit1_q     <= 1'b0;
    end else begin
      if (wr_ctl0) ctl0_q <= reg_wdata;
      if (wr_ctl1) ctl1_q <= reg_wdata;
      if (wr_base0) base0_q <= reg_wdata[31:16] & m0;
      if (wr_base1) base1_q <= reg_wdata[31:16] & m1;
      if (wr_ta0) ta0_q <= reg_wdata[31:16];
      if (wr_ta1) ta1_q <= reg_wdata[31:16];
      if (wr_misc1) misc1_q <= reg_wdata[11:0];
      if (wr_misc2) misc2_q <= reg_wdata[11:0];
      // Set wins over a same-cycle write-one clear
      if (cs_clash) begin
        conflict_q <= 1'b1;
      end else if (wr_stat && reg_wdata[STAT_CS_CONFLICT]) begin
        conflict_q <= 1'b0;
      end
      if (state_q == ST_DECODE && hit) begin
        hit0_q <= match0;
        hit1_q <= !match0;
      end
    end
  end

  // Register reads, answered the cycle after the strobe
  logic [31:0] status_word, rd_mux;

  always_comb begin
    status_word = '0;
    status_word[STAT_SPEED_LSB +: 2] = DEVSEL_MEDIUM;
    status_word[STAT_HIT0]        = hit0_q;
    status_word[STAT_HIT1]        = hit1_q;
    status_word[STAT_BUSY]        = lb_valid_q;
    status_word[STAT_CS_CONFLICT] = conflict_q;
  end

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      reg_at(IDX_IMAGE0_CONTROL): rd_mux = ctl0_q;
      reg_at(IDX_IMAGE1_CONTROL): rd_mux = ctl1_q;
      reg_at(IDX_IMAGE0_BASE):    rd_mux = {base0_q & m0, 16'h0000};
      reg_at(IDX_IMAGE1_BASE):    rd_mux = {base1_q & m1, 16'h0000};
      reg_at(IDX_IMAGE0_XLATE):   rd_mux = {ta0_q, 16'h0000};
      reg_at(IDX_IMAGE1_XLATE):   rd_mux = {ta1_q, 16'h0000};
      reg_at(IDX_MISC_PRIMARY):   rd_mux = {20'h00000, misc1_q};
      reg_at(IDX_MISC_SECONDARY): rd_mux = {20'h00000, misc2_q};
      reg_at(IDX_STATUS):         rd_mux = status_word;
      default:                     rd_mux = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst || !reg_read) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

/* tb/pci_target_image_decode_assertions.sv */
// Port-level assertions for the PCI target image decode stage
`timescale 1ns/1ps
`default_nettype none
module pci_target_image_decode_assertions (
  // Clock and reset
  input wire logic                           clock,
  input wire logic                           srst,
  // Register port
  input wire logic [7:0]                     reg_addr,
  input wire logic                           reg_read,
  input wire logic [31:0]                    reg_rdata,
  // PCI side
  input wire logic                           frame_n,
  input wire logic                           irdy_n,
  input wire logic                           devsel_n_out,
  input wire logic                           devsel_oe,
  // Local side
  input wire logic                           lb_valid,
  input wire logic                           lb_ready,
  input wire target_decode_pkg::local_bus_req_t lb_req,
  input wire logic [3:0]                     transaction_code,
  input wire logic                           cfg_valid
);
  import target_decode_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence claim_s;
    $fell(devsel_n_out);
  endsequence
  sequence release_s;
    devsel_n_out && devsel_oe ##1 !devsel_oe;
  endsequence
  devsel_speed_a: assert property (claim_s |->
    !$past(frame_n, 2) && $past(frame_n, 3)) else $error("late claim");
  valid_claim_a: assert property ($rose(lb_valid) |-> claim_s)
    else $error("request without claim");
  valid_hold_a: assert property (lb_valid && !lb_ready |=>
    lb_valid && $stable(lb_req)) else $error("request dropped");
  code_copy_a: assert property (lb_valid |->
    transaction_code == lb_req.transaction_code) else $error("code lines");
  oe_drive_a: assert property (!devsel_n_out |-> devsel_oe)
    else $error("devsel not driven");
  devsel_release_a: assert property (
    !devsel_n_out && frame_n && irdy_n |=> release_s) else $error("release");
  cfg_local_a: assert property (cfg_valid |-> (!lb_valid) and claim_s)
    else $error("config forwarded");
  cfg_pulse_a: assert property (cfg_valid |=> !cfg_valid)
    else $error("config pulse long");
  speed_status_a: assert property (
    $past(reg_read) && $past(reg_addr) == 8'h20 |->
    reg_rdata[1:0] == DEVSEL_MEDIUM) else $error("speed field");
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data stands");
endmodule
bind pci_target_image_decode pci_target_image_decode_assertions i_chk (
  .clock, .srst, .reg_addr, .reg_read, .reg_rdata, .frame_n, .irdy_n,
  .devsel_n_out, .devsel_oe, .lb_valid, .lb_ready, .lb_req,
  .transaction_code, .cfg_valid);
`default_nettype wire

/* tb/pci_master_model.sv */
// PCI master and local-bus slave model facing the decode stage
`timescale 1ns/1ps
`default_nettype none
module pci_master_model (
  // Clock
  input  wire logic        clock,
  // PCI side
  output logic             frame_n,
  output logic             irdy_n,
  output logic             idsel,
  output logic [31:0]      ad_in,
  output logic [3:0]       cbe_n,
  input  wire logic        devsel_n_out,
  // Local side
  input  wire logic        slow,
  output logic             lb_ready
);
  logic [1:0] cnt_q = 2'h0;
  initial begin
    frame_n = 1'b1;
    irdy_n = 1'b1;
    idsel = 1'b0;
    ad_in = 32'h0;
    cbe_n = 4'hF;
    lb_ready = 1'b0;
  end
  // Slow mode accepts one cycle in four
  always @(posedge clock) begin
    cnt_q <= cnt_q + 2'h1;
    lb_ready <= !slow || cnt_q == 2'h3;
  end
  // One address phase and one data phase, then the bus is released
  task automatic cycle(input logic [31:0] a, input logic [3:0] c,
                       input logic sel);
    @(posedge clock);
    frame_n <= 1'b0;
    ad_in <= a;
    cbe_n <= c;
    idsel <= sel;
    @(posedge clock);
    frame_n <= 1'b1;
    irdy_n <= 1'b0;
    ad_in <= ~a;
    cbe_n <= 4'h0;
    idsel <= 1'b0;
    for (int n = 0; n < 4 && devsel_n_out !== 1'b0; n++) @(negedge clock);
    @(posedge clock);
    irdy_n <= 1'b1;
    ad_in <= a;
  endtask
endmodule
`default_nettype wire

/* tb/pci_target_image_decode_tb.sv */
// Self-checking bench for the PCI target image decode stage
`timescale 1ns/1ps
`default_nettype none
module pci_target_image_decode_tb;
  import target_decode_pkg::*;
  logic           clock = 1'b0;
  logic           srst = 1'b1;
  logic [7:0]     reg_addr = 8'h00;
  logic [31:0]    reg_wdata = 32'h0;
  logic           reg_write = 1'b0;
  logic           reg_read = 1'b0;
  logic           slow = 1'b0;
  logic           lb_mastering = 1'b0;
  logic           register_chip_select_n = 1'b1;
  logic           config_chip_select_n = 1'b1;
  logic           clash = 1'b0;
  logic [31:0]    reg_rdata, ad_in;
  logic           frame_n, irdy_n, idsel, devsel_n_out, devsel_oe;
  logic           lb_valid, lb_ready, cfg_valid;
  logic [3:0]     cbe_n, transaction_code;
  local_bus_req_t lb_req, got_q, e;
  config_req_t    cfg_req, cfg_q;
  int             n_errors = 0, check_count = 0, got_n = 0, cfg_n = 0;
  int             seed = 32'h45C5842C;
  logic [3:0]     mc [5] = '{CMD_MEM_READ, CMD_MEM_WRITE, CMD_MEM_RD_MUL,
                             CMD_MEM_RD_LN, CMD_MEM_WR_INV};
  pci_target_image_decode i_pci_target_image_decode (.clock, .srst,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .frame_n,
    .irdy_n, .idsel, .ad_in, .cbe_n, .devsel_n_out, .devsel_oe, .lb_valid,
    .lb_ready, .lb_req, .transaction_code, .lb_mastering,
    .register_chip_select_n, .config_chip_select_n, .cfg_valid, .cfg_req);
  pci_master_model i_pci_master_model (.clock, .frame_n, .irdy_n, .idsel,
    .ad_in, .cbe_n, .devsel_n_out, .slow, .lb_ready);
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (lb_valid && lb_ready) begin
      got_q <= lb_req;
      got_n <= got_n + 1;
    end
    if (cfg_valid) begin
      cfg_n <= cfg_n + 1;
      cfg_q <= cfg_req;
    end
    lb_mastering <= (lb_valid && lb_ready) || clash;
    // Chip selects wander only while the block is not mastering
    register_chip_select_n <= !clash
      && ((lb_valid && lb_ready) || 1'($random(seed)));
    config_chip_select_n <= !clash
      && ((lb_valid && lb_ready) || 1'($random(seed)));
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic pci(input logic [31:0] a, input logic [3:0] c,
                     input logic sel, input int hits);
    int g;
    g = got_n;
    i_pci_master_model.cycle(a, c, sel);
    @(negedge clock);
    for (int n = 0; n < 20 && lb_valid !== 1'b0; n++) @(negedge clock);
    check(got_n - g, hits);
    repeat (3) @(posedge clock);
  endtask
  function automatic logic [31:0] xl(input logic [31:0] a,
                                     input logic [15:0] t,
                                     input logic [3:0] b);
    logic [31:0] m;
    m = 32'hFFFF_FFFF << (16 + b);
    return ({t, 16'h0} & m) | (a & ~m);
  endfunction
  initial begin
    #300000;
    n_errors++;
    end_sim;
  end
  initial begin : main
    logic [31:0] d, a, bs, m, ctl, r, m1, m2;
    logic [15:0] t;
    logic [7:0]  o;
    logic [3:0]  b, c;
    logic        s, k;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    rd(8'h00, d);
    check(d, 0);
    rd(8'h20, d);
    check(d & 32'h3F, 32'h1);
    rd(8'h40, d);
    check(d, 0);
    for (int i = 0; i < 24; i++) begin
      b = (i < 2) ? 4'(i * 15) : 4'($random(seed));
      m = 32'hFFFF_FFFF << (16 + b);
      s = (i % 3 == 0);
      k = i[0];
      o = {5'h0, k, 2'h0};
      r = $random(seed);
      bs = $random(seed);
      t = 16'($random(seed));
      m1 = $random(seed);
      m2 = $random(seed);
      c = s ? (r[0] ? CMD_IO_WRITE : CMD_IO_READ) : mc[i % 5];
      ctl = {1'b1, s, r[29:20], b, 16'h0};
      a = ($random(seed) & ~m) | (bs & m);
      wr(8'h00 + o, ctl);
      wr(8'h08 + o, bs);
      wr(8'h10 + o, {t, 16'h0});
      wr(8'h18, m1);
      wr(8'h1C, m2);
      rd(8'h08 + o, d);
      check(d, bs & m);
      slow <= r[31];
      pci(a, c, 1'b0, 1);
      e = '{xl(a, t, b), ctl[23:20], c[0], s, k, ctl[29] & c[0],
            ctl[25:24], ctl[28] & !c[0], ctl[27] & c[0], m1[8] ^ ctl[26],
            (k && m2[8]) ? m2[5:0] : m1[5:0], m2[9], m2[10], m2[11]};
      check(got_q.address, e.address);
      check(got_q.transaction_code, e.transaction_code);
      check(got_q[17:9], e[17:9]);
      check(got_q[8:0], e[8:0]);
      rd(8'h20, d);
      check(d[4:2], k ? 3'b010 : 3'b001);
      pci(a ^ (32'h1_0000 << b), c, 1'b0, 0);
      pci(a, s ? CMD_MEM_READ : CMD_IO_READ, 1'b0, 0);
      wr(8'h00 + o, 32'h0);
      pci(a, c, 1'b0, 0);
    end
    pci(32'h0000_0010, CMD_CFG_READ, 1'b1, 0);
    pci(32'h0000_0014, CMD_CFG_WRITE, 1'b1, 0);
    check(cfg_q, {1'b1, 6'h05, 4'h0});
    pci(32'h0000_0011, CMD_CFG_READ, 1'b1, 0);
    check(cfg_n, 2);
    rd(8'h20, d);
    check(d[5], 0);
    // Deliberate chip-select clash sets the sticky flag; write one clears
    clash <= 1'b1;
    repeat (2) @(posedge clock);
    clash <= 1'b0;
    rd(8'h20, d);
    check(d[5], 1);
    wr(8'h20, 32'h20);
    rd(8'h20, d);
    check(d[5], 0);
    end_sim;
  end
endmodule
`default_nettype wire
